// ---- rtl/security_register_erase.sv ----
// Serial command decoder and timed eraser for three security registers
`timescale 1ns/1ns
`default_nettype none
`include "secreg_erase_regs.svh"

module security_register_erase #(
   parameter int ERASE_CYCLES = `SRE_TSE_US * `SRE_CLK_MHZ
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Serial link from the host
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic serial_out_oe,
   // Configuration and status
   input wire logic addr4_mode,
   input wire logic [2:0] security_lock_bits,
   output logic busy,
   output logic write_enable_latch,
   // Array access for the read and program paths
   input wire logic [9:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic prog_we,
   input wire logic [9:0] prog_addr,
   input wire logic [7:0] prog_data
);

   // ****************************************************************
   // Pin synchronisers and edge detection
   // ****************************************************************
   logic [2:0] sclk_sync, cs_sync;
   logic [1:0] si_sync;

   // Two flops before use; third sclk/cs stage only for edge finding
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sclk_sync <= 3'h0;
         cs_sync <= 3'h7;
         si_sync <= 2'h0;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], spi_clk};
         cs_sync <= {cs_sync[1:0], cs_n};
         si_sync <= {si_sync[0], serial_in_line};
      end
   end

   logic sclk_rise, sclk_fall, cs_rise, sel_low;
   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign cs_rise = cs_sync[1] & ~cs_sync[2];
   assign sel_low = ~cs_sync[1];

   // ****************************************************************
   // Command shifter
   // ****************************************************************
   logic [39:0] shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [7:0] opcode_reg;

   // Count saturates so an overlong frame can never wrap to a legal length
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         shift_reg <= 40'h0;
         bit_cnt_reg <= 6'h0;
         opcode_reg <= 8'h00;
      end
      else if (!sel_low)
         bit_cnt_reg <= 6'h0;
      else if (sclk_rise)
      begin
         shift_reg <= {shift_reg[38:0], si_sync[1]};
         if (bit_cnt_reg != 6'h3f)
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         if (bit_cnt_reg == `SRE_BITS_OP - 6'h01)
            opcode_reg <= {shift_reg[6:0], si_sync[1]};
      end
   end

   // ****************************************************************
   // Erase command check
   // ****************************************************************
   logic [31:0] addr_word;
   logic [7:0] frame_op;
   logic [5:0] need_bits;
   logic addr_ok, len_ok, erase_go;
   logic [1:0] reg_sel;
   secreg_erase_pkg::seq_state_t state_reg;

   assign addr_word = addr4_mode ? shift_reg[31:0]
                                 : {8'h00, shift_reg[23:0]};
   assign frame_op = addr4_mode ? shift_reg[39:32] : shift_reg[31:24];
   assign need_bits = addr4_mode ? `SRE_BITS_4B : `SRE_BITS_3B;
   assign len_ok = (bit_cnt_reg == need_bits);
   assign reg_sel = addr_word[13:12] - 2'h1;
   // Upper word zero, bits 11:8 zero, bits 15:12 one of 1..3
   assign addr_ok = (addr_word[31:16] == 16'h0000)
                  && (addr_word[11:8] == 4'h0)
                  && (addr_word[15:14] == 2'h0)
                  && (addr_word[13:12] != 2'h0);
   // Lock bits gate the start, so a locked register is never erased
   assign erase_go = cs_rise && state_reg == secreg_erase_pkg::ST_IDLE
                   && len_ok && frame_op == `SRE_OP_ERASE
                   && write_enable_latch && addr_ok
                   && !security_lock_bits[reg_sel];

   // ****************************************************************
   // Erase sequencer
   // ****************************************************************
   logic [31:0] timer_reg;
   logic [8:0] wipe_ptr_reg;
   logic [1:0] target_reg;

   // Timed erase; the array wipe runs one byte per clock inside it
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= secreg_erase_pkg::ST_IDLE;
         timer_reg <= 32'h0;
         wipe_ptr_reg <= 9'h0;
         target_reg <= 2'h0;
      end
      else
      begin
         unique case (state_reg)
            secreg_erase_pkg::ST_IDLE:
            begin
               if (erase_go)
               begin
                  state_reg <= secreg_erase_pkg::ST_ERASE;
                  timer_reg <= 32'(ERASE_CYCLES - 1);
                  wipe_ptr_reg <= 9'h0;
                  target_reg <= reg_sel;
               end
            end
            secreg_erase_pkg::ST_ERASE:
            begin
               if (wipe_ptr_reg != 9'(`SRE_REG_BYTES))
                  wipe_ptr_reg <= wipe_ptr_reg + 9'h001;
               if (timer_reg == 32'h0)
                  state_reg <= secreg_erase_pkg::ST_IDLE;
               else
                  timer_reg <= timer_reg - 32'h1;
            end
         endcase
      end
   end

   // Busy mirrors the sequencer but is its own flop for a clean output
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         busy <= 1'b0;
      else if (erase_go)
         busy <= 1'b1;
      else if (state_reg == secreg_erase_pkg::ST_ERASE && timer_reg == 32'h0)
         busy <= 1'b0;
   end

   // ****************************************************************
   // Write enable latch
   // ****************************************************************
   logic op_frame_end;
   assign op_frame_end = cs_rise && bit_cnt_reg == `SRE_BITS_OP && !busy;

   // Commands other than status read are ignored while busy
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         write_enable_latch <= 1'b0;
      else if (busy && state_reg == secreg_erase_pkg::ST_ERASE
               && timer_reg == 32'h0)
         write_enable_latch <= 1'b0;
      else if (op_frame_end && opcode_reg == `SRE_OP_WREN)
         write_enable_latch <= 1'b1;
      else if (op_frame_end && opcode_reg == `SRE_OP_WRDI)
         write_enable_latch <= 1'b0;
   end

   // ****************************************************************
   // Status read output
   // ****************************************************************
   logic [7:0] status_byte;
   assign status_byte = {6'h00, write_enable_latch, busy};

   // Status byte repeats MSB first for seven bytes, then holds bit 0 as the count saturates
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         serial_out_line <= 1'b0;
         serial_out_oe <= 1'b0;
      end
      else if (!sel_low)
         serial_out_oe <= 1'b0;
      else if (sclk_fall && bit_cnt_reg >= `SRE_BITS_OP
               && opcode_reg == `SRE_OP_RDSR)
      begin
         serial_out_oe <= 1'b1;
         serial_out_line <= status_byte[~bit_cnt_reg[2:0]];
      end
   end

   // ****************************************************************
   // Security register array
   // ****************************************************************
   logic [7:0] sec_mem [0:767];
   logic wipe_en, prog_ok;
   logic [9:0] wipe_addr;

   assign wipe_en = state_reg == secreg_erase_pkg::ST_ERASE
                  && wipe_ptr_reg != 9'(`SRE_REG_BYTES);
   assign wipe_addr = {target_reg, wipe_ptr_reg[7:0]};
   // Programming can only clear bits on bytes that still read erased
   assign prog_ok = prog_we && !busy && prog_addr < 10'h300
                  && sec_mem[prog_addr] == `SRE_ERASED;

   // Array has no reset; contents survive like the nonvolatile cells
   always_ff @(posedge ref_clk)
   begin
      if (wipe_en)
         sec_mem[wipe_addr] <= `SRE_ERASED;
      else if (prog_ok)
         sec_mem[prog_addr] <= prog_data;
   end

   // Out-of-range reads return the erased value
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rd_data <= `SRE_ERASED;
      else if (rd_addr < 10'h300)
         rd_data <= sec_mem[rd_addr];
      else
         rd_data <= `SRE_ERASED;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   go_sets_busy_a: assert property (erase_go |=> busy)
      else $error("erase start did not raise busy");
   no_wel_no_go_a: assert property (
      cs_rise && !write_enable_latch |=> !$rose(busy))
      else $error("erase started with latch clear");
   locked_skip_a: assert property (
      cs_rise && security_lock_bits[reg_sel] |=> !$rose(busy))
      else $error("erase started on a locked register");
   bad_len_a: assert property (cs_rise && !len_ok |=> !$rose(busy))
      else $error("erase started on wrong frame length");
   bad_addr_a: assert property (
      erase_go |-> addr_word[15:12] inside {4'h1, 4'h2, 4'h3}
      && addr_word[11:8] == 4'h0)
      else $error("erase started on illegal address");
   busy_span_a: assert property ($rose(busy) |-> busy [*8])
      else $error("busy dropped early");
   wel_clear_a: assert property ($fell(busy) |-> !write_enable_latch)
      else $error("latch not cleared after erase");
   reject_idle_a: assert property (!busy && !erase_go |=> !busy)
      else $error("busy rose without a valid erase");
   status_drive_a: assert property (
      busy && sel_low && sclk_fall && bit_cnt_reg >= `SRE_BITS_OP
      && opcode_reg == `SRE_OP_RDSR |=> serial_out_oe && serial_out_line
      == $past(status_byte[~bit_cnt_reg[2:0]]))
      else $error("status not answered during erase");
   wipe_ff_a: assert property (
      wipe_en |=> sec_mem[$past(wipe_addr)] == `SRE_ERASED)
      else $error("erased byte not FFh");

   // Erase end seen with the latch already cleared
   erase_run_c: cover property ($fell(busy) && !write_enable_latch);
   locked_c: cover property (cs_rise && len_ok && write_enable_latch
      && addr_ok && security_lock_bits[reg_sel]);
   poll_c: cover property (busy && serial_out_oe);
   four_byte_c: cover property (erase_go && addr4_mode);

endmodule : security_register_erase
`default_nettype wire

// ---- rtl/secreg_erase_regs.svh ----
// Constants for the security register erase sequencer
`ifndef SECREG_ERASE_REGS_SVH
`define SECREG_ERASE_REGS_SVH

// Opcodes
`define SRE_OP_ERASE 8'h44
`define SRE_OP_RDSR 8'h05
`define SRE_OP_WREN 8'h06
`define SRE_OP_WRDI 8'h04

// Frame lengths in serial clocks
`define SRE_BITS_3B 6'h20
`define SRE_BITS_4B 6'h28
`define SRE_BITS_OP 6'h08

// Status byte fields
`define SRE_ST_BUSY 0
`define SRE_ST_WEL 1

// Erased byte value and register size
`define SRE_ERASED 8'hff
`define SRE_REG_BYTES 256

// Timing: erase time in microseconds, clock in MHz
`define SRE_TSE_US 1000
`define SRE_CLK_MHZ 20

`endif

// ---- rtl/secreg_erase_pkg.sv ----
// Types for the security register erase sequencer
package secreg_erase_pkg;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ERASE = 1'b1
   } seq_state_t;
endpackage : secreg_erase_pkg

// ---- sim/host_spi_model.sv ----
// Host serial controller model that frames commands into the flash block
`timescale 1ns/1ns
`default_nettype none

module host_spi_model (
   // System clock used to pace the link
   input wire logic ref_clk,
   // Serial link towards the device
   output logic spi_clk,
   output logic cs_n,
   output logic serial_in_line,
   input wire logic serial_out_line,
   input wire logic serial_out_oe
);
   // *******************************************************
   // Frame engine, mode 0, MSB first, 400 ns link period
   // *******************************************************
   // Link idles with the clock low and chip select high
   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      serial_in_line = 1'b0;
   end

   // Bits are left aligned; an unanswered bit reads as unknown on purpose
   task automatic frame(input logic [39:0] bits, input int n,
      output logic [7:0] rx);
      rx = 8'h00;
      @(negedge ref_clk);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++)
      begin
         serial_in_line = bits[39 - i];
         repeat (4) @(negedge ref_clk);
         spi_clk = 1'b1;
         rx = {rx[6:0], serial_out_oe ? serial_out_line : 1'bx};
         repeat (4) @(negedge ref_clk);
         spi_clk = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      cs_n = 1'b1;
      // Released data line flips so a stale level is never trusted
      serial_in_line = ~serial_in_line;
      repeat (8) @(negedge ref_clk);
   endtask : frame
endmodule : host_spi_model
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the security register erase sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
   begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value %s exp %h got %h", what, exp, got); end end

module tb;
   // *******************************************************
   // Signals, design and host model
   // *******************************************************
   logic ref_clk = 1'b0;
   logic reset_n, spi_clk, cs_n, serial_in_line, serial_out_line;
   logic serial_out_oe, addr4_mode, busy, write_enable_latch, prog_we;
   logic [2:0] security_lock_bits;
   logic [9:0] rd_addr, prog_addr;
   logic [7:0] rd_data, prog_data, rx;
   logic [23:0] bad_addr [4] = '{24'h011000, 24'h001100, 24'h004000,
      24'h000000};
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int start;

   always #25 ref_clk = ~ref_clk;

   security_register_erase #(.ERASE_CYCLES(300)) dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .spi_clk(spi_clk), .cs_n(cs_n),
      .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
      .serial_out_oe(serial_out_oe), .addr4_mode(addr4_mode),
      .security_lock_bits(security_lock_bits), .busy(busy),
      .write_enable_latch(write_enable_latch), .rd_addr(rd_addr),
      .rd_data(rd_data), .prog_we(prog_we), .prog_addr(prog_addr),
      .prog_data(prog_data));

   host_spi_model host (.ref_clk(ref_clk), .spi_clk(spi_clk), .cs_n(cs_n),
      .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
      .serial_out_oe(serial_out_oe));

   // Ceiling well above the expected run of about 6000 cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic cmd(input logic [7:0] op);
      host.frame({op, 32'h0}, 8, rx);
   endtask : cmd

   task automatic status(input logic [7:0] exp);
      host.frame({8'h05, 32'h0}, 16, rx);
      `CHK("status", exp, rx)
   endtask : status

   // Busy length is timed from frame end, about 8 cycles after cs_n rose
   task automatic erase(input logic [39:0] bits, input int n,
      input logic run);
      host.frame(bits, n, rx);
      start = cycles;
      `CHK("busy", run, busy)
      if (run)
      begin
         // Latch clear is ignored while busy, so status still shows it set
         cmd(8'h04);
         status(8'h03);
         while (busy === 1'b1 && cycles - start < 400)
            @(negedge ref_clk);
         `CHK("erase time", 1'b1, (cycles - start) inside {[285:300]})
         `CHK("latch after erase", 1'b0, write_enable_latch)
      end
   endtask : erase

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      rd_addr = a;
      repeat (2) @(negedge ref_clk);
      `CHK("array byte", exp, rd_data)
   endtask : rd

   task automatic prog(input logic [9:0] a, input logic [7:0] d);
      prog_we = 1'b1;
      prog_addr = a;
      prog_data = d;
      @(negedge ref_clk);
      prog_we = 1'b0;
   endtask : prog

   // Main sequence: refusal without the latch, erase each register, then the other refusals and a four-byte erase
   initial
   begin
      reset_n = 1'b0;
      addr4_mode = 1'b0;
      security_lock_bits = 3'h0;
      rd_addr = 10'h000;
      prog_we = 1'b0;
      prog_addr = 10'h000;
      prog_data = 8'h00;
      repeat (16) @(negedge ref_clk);
      `CHK("reset busy", 1'b0, busy)
      `CHK("reset latch", 1'b0, write_enable_latch)
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      erase({8'h44, 24'h001000, 8'h00}, 32, 1'b0);
      for (int r = 1; r <= 3; r++)
      begin
         cmd(8'h06);
         status(8'h02);
         erase({8'h44, 8'h00, r[3:0], 4'h0, 8'h5a, 8'h00}, 32, 1'b1);
         rd({r[1:0] - 2'h1, 8'hff}, 8'hff);
         prog({r[1:0] - 2'h1, 8'h07}, 8'h3c);
         rd({r[1:0] - 2'h1, 8'h07}, 8'h3c);
      end
      prog(10'h007, 8'h00);
      rd(10'h007, 8'h3c);
      cmd(8'h06);
      security_lock_bits = 3'h1;
      erase({8'h44, 24'h001000, 8'h00}, 32, 1'b0);
      security_lock_bits = 3'h0;
      erase({8'h44, 24'h001000, 8'h00}, 31, 1'b0);
      erase({8'h44, 24'h001000, 8'h00}, 33, 1'b0);
      foreach (bad_addr[k])
         erase({8'h44, bad_addr[k], 8'h00}, 32, 1'b0);
      addr4_mode = 1'b1;
      erase({8'h44, 24'h001000, 8'h00}, 32, 1'b0);
      rd(10'h007, 8'h3c);
      status(8'h02);
      security_lock_bits = 3'h6;
      erase({8'h44, 32'h00001077}, 40, 1'b1);
      rd(10'h007, 8'hff);
      cmd(8'h06);
      cmd(8'h04);
      status(8'h00);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
